// file: rtl/eomac_pkg.sv
// Package: register map, field positions and types for the angle config bank
package eomac_pkg;

  // Register indices (printed offsets are not multiples of four)
  localparam logic [7:0] ERROR_MASK_CONFIG_IDX       = 8'h1a;
  localparam logic [7:0] INTERFACE_OUTPUT_CONFIG_IDX = 8'h1b;
  localparam logic [7:0] ANGLE_PROCESSING_CONFIG_IDX = 8'h1c;
  localparam logic [7:0] ERROR_STATUS_IDX            = 8'h1d;
  localparam logic [7:0] ANGLE_STATUS_IDX            = 8'h1e;
  localparam logic [7:0] LIN_SEG_IDX                 = 8'h20;

  // Reset values
  localparam logic [23:0] CFG_RESET = 24'h00_0000;

  // Field positions
  localparam int WARN_MASK_BIT  = 11;
  localparam int CRC_CHK_BIT    = 0;
  localparam int XCLK_TOL_BIT   = 1;
  localparam int TURNS_HYS_BIT  = 2;
  localparam int SUPPLY_DIS_BIT = 3;
  localparam int ZERO_AFTER_BIT = 7;
  localparam int LIN_SCALE_BIT  = 10;
  localparam int LIN_EN_BIT     = 11;
  localparam int ERR_SEL_BIT    = 12;
  localparam int ERR_OUT_BIT    = 13;
  localparam int PWM_HYS_BIT    = 14;
  localparam int PWM_EN_BIT     = 23;
  localparam int DIR_BIT        = 18;
  localparam int DIE_ROT_BIT    = 19;

  // Angle and averaging constants
  localparam logic [11:0] HALF_TURN   = 12'h800;
  localparam logic [3:0]  ORATE_MAX   = 4'hc;
  localparam int          LIN_SEGS    = 32;
  localparam logic [4:0]  ERR_SOURCES = 5'h18;

  // Processing mode of the PWM pin
  typedef enum logic [1:0] { EOMAC_PWM_OFF, EOMAC_PWM_ANGLE,
                             EOMAC_PWM_TRI, EOMAC_PWM_ERR } eomac_pwm_t;

  // Decoded controls handed to the serial/PWM blocks
  typedef struct packed {
    logic       crc_check_enable;
    logic       extra_clock_tolerance;
    logic       supply_protocol_disable;
    logic       linearization_scale;
    logic [3:0] pwm_freq_sel;
    logic [2:0] pwm_band_sel;
    logic       pwm_half_freq;
  } eomac_ctrl_t;

endpackage : eomac_pkg

// file: rtl/eomac_config.sv
// Error mask, output and angle processing configuration bank
//
// The Avalon-MM slave port was chosen for this implementation.
`timescale 1ns/10ps

// Contract
// - Set mask bit hides error from flag
// - Warning mask keeps warning summary clear
// - CRC checked only when enable set
// - Tolerance bit ignores seventeenth serial clock
// - Turns angle uses hysteresis when selected
// - Supply-pin protocol ignored when disabled
// - Offset placement before or after linearization
// - Scale bit picks 22.5 or 45 range
// - Linearization applied only when enabled
// - Error tristates PWM until reset/clear
// - Error mode halves frequency, error duty
// - PWM angle hysteresis-filtered when enabled
// - Frequency select plus band set carrier
// - PWM driven only when enabled
// - Zero offset subtracted from angle
// - Hysteresis threshold in 14-bit LSBs
// - Direction bit flips angle sense
// - Die rotate adds 180 degrees last
// - Average 2^rate samples, rate clamped 12
// - Each error has its own duty
// - Segment correction subtracted from angle
module eomac_config
  import eomac_pkg::*;
(
  input  wire logic                 CLK,          // 20 MHz clock
  input  wire logic                 RESET,        // Sync reset, high
  input  wire logic [9:0]           AVS_ADDRESS,  // Word address
  input  wire logic                 AVS_READ,     // Read request
  input  wire logic                 AVS_WRITE,    // Write request
  input  wire logic [31:0]          AVS_WRITEDATA, // Write data
  input  wire logic [3:0]           AVS_BYTEENABLE, // Byte lanes
  output logic [31:0]               AVS_READDATA, // Read data
  output logic                      AVS_WAITREQUEST, // Stall
  input  wire logic                 SAMPLE_VALID, // New raw sample
  input  wire logic [13:0]          SAMPLE_ANGLE, // Raw 14-bit angle
  input  wire logic [23:0]          ERROR_SOURCES, // Active errors
  input  wire logic                 WARNING_ACTIVE, // Unmasked warning
  output logic                      AGGREGATE_ERROR_FLAG, // Error flag
  output logic                      WARNING_SUMMARY_BIT, // Warning bit
  output logic [11:0]               OUTPUT_ANGLE, // Processed angle
  output logic                      OUTPUT_VALID, // Averaged strobe
  output logic [11:0]               TURNS_ANGLE_REGISTER, // Turns angle
  output logic [11:0]               PWM_ANGLE,    // Angle for PWM
  output logic [4:0]                PWM_ERROR_CODE, // Error duty index
  output eomac_pkg::eomac_pwm_t     PWM_MODE,     // PWM pin mode
  output logic                      PWM_OE,       // PWM output enable
  output eomac_pkg::eomac_ctrl_t    CTRL          // Serial/PWM controls
);
  import eomac_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Registers
  logic [23:0] error_mask_config_reg;
  logic [23:0] interface_output_config_reg;
  logic [23:0] angle_processing_config_reg;
  logic [11:0] lin_seg_reg [LIN_SEGS];
  logic        pwm_latch_reg;
  logic        rd_pend_reg;
  logic [13:0] hys_angle_reg;
  logic [25:0] acc_reg;
  logic [12:0] cnt_reg;
  logic [11:0] post_angle;

  // Byte-enable merge of a 24-bit word
  function automatic logic [23:0] merge(input logic [23:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  be);
    logic [23:0] r;
    r = old;
    for (int i = 0; i < 3; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  logic wr_go;
  assign wr_go = AVS_WRITE && !AVS_WAITREQUEST;

  ////////////////////////////////////////////////////////////////////////
  // Configuration words, written on the accepting edge
  always_ff @(posedge CLK) begin
    if (RESET) begin
      error_mask_config_reg       <= CFG_RESET;
      interface_output_config_reg <= CFG_RESET;
      angle_processing_config_reg <= CFG_RESET;
    end else if (wr_go) begin
      if (AVS_ADDRESS == {2'b00, ERROR_MASK_CONFIG_IDX}) begin
        error_mask_config_reg <= merge(error_mask_config_reg,
                                       AVS_WRITEDATA, AVS_BYTEENABLE);
      end
      if (AVS_ADDRESS == {2'b00, INTERFACE_OUTPUT_CONFIG_IDX}) begin
        interface_output_config_reg <= merge(interface_output_config_reg,
                                             AVS_WRITEDATA, AVS_BYTEENABLE);
      end
      if (AVS_ADDRESS == {2'b00, ANGLE_PROCESSING_CONFIG_IDX}) begin
        angle_processing_config_reg <= merge(angle_processing_config_reg,
                                             AVS_WRITEDATA, AVS_BYTEENABLE);
      end
    end
  end

  // Segment correction table, one word per segment
  genvar g;
  generate
    for (g = 0; g < LIN_SEGS; g++) begin : g_seg
      always_ff @(posedge CLK) begin
        if (RESET) begin
          lin_seg_reg[g] <= 12'h000;
        end else if (wr_go && AVS_ADDRESS ==
                     10'({2'b00, LIN_SEG_IDX} + 10'(g))) begin
          lin_seg_reg[g] <= 12'(merge({12'h000, lin_seg_reg[g]},
                                      AVS_WRITEDATA, AVS_BYTEENABLE));
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Bus answer: one wait cycle, then read data with waitrequest low
  always_ff @(posedge CLK) begin
    if (RESET) begin
      rd_pend_reg <= 1'b0;
    end else begin
      rd_pend_reg <= (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST &&
                     !rd_pend_reg;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      AVS_WAITREQUEST <= 1'b1;
    end else begin
      // Drop for one cycle once the request has waited one edge
      AVS_WAITREQUEST <= !((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST &&
                          !rd_pend_reg);
    end
  end

  // Unmapped words read as zero, writes to them are dropped
  always_ff @(posedge CLK) begin
    if (RESET) begin
      AVS_READDATA <= 32'h0000_0000;
    end else begin
      case (AVS_ADDRESS)
        {2'b00, ERROR_MASK_CONFIG_IDX}:
          AVS_READDATA <= {8'h00, error_mask_config_reg};
        {2'b00, INTERFACE_OUTPUT_CONFIG_IDX}:
          AVS_READDATA <= {8'h00, interface_output_config_reg};
        {2'b00, ANGLE_PROCESSING_CONFIG_IDX}:
          AVS_READDATA <= {8'h00, angle_processing_config_reg};
        {2'b00, ERROR_STATUS_IDX}:
          AVS_READDATA <= {29'h0, pwm_latch_reg, WARNING_SUMMARY_BIT,
                           AGGREGATE_ERROR_FLAG};
        {2'b00, ANGLE_STATUS_IDX}:
          AVS_READDATA <= {8'h00, TURNS_ANGLE_REGISTER, OUTPUT_ANGLE};
        default: begin
          if (AVS_ADDRESS >= {2'b00, LIN_SEG_IDX} &&
              AVS_ADDRESS < 10'({2'b00, LIN_SEG_IDX} + 10'(LIN_SEGS))) begin
            AVS_READDATA <= {20'h0,
              lin_seg_reg[5'(AVS_ADDRESS - {2'b00, LIN_SEG_IDX})]};
          end else begin
            AVS_READDATA <= 32'h0000_0000;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Error aggregation
  always_ff @(posedge CLK) begin
    if (RESET) begin
      AGGREGATE_ERROR_FLAG <= 1'b0;
      WARNING_SUMMARY_BIT  <= 1'b0;
    end else begin
      AGGREGATE_ERROR_FLAG <= |(ERROR_SOURCES & ~error_mask_config_reg);
      WARNING_SUMMARY_BIT <= WARNING_ACTIVE &&
                             !error_mask_config_reg[WARN_MASK_BIT];
    end
  end

  // Lowest active enabled source is the highest priority error
  function automatic logic [4:0] first_err(input logic [23:0] e);
    logic [4:0] r;
    r = ERR_SOURCES;
    for (int i = 23; i >= 0; i--) begin
      if (e[i]) begin
        r = 5'(i);
      end
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Angle pipeline, combinational from the latest sample
  logic [11:0] raw12, seg_corr, lin_angle, dir_angle, pre_off, lin_in;
  always_comb begin
    raw12 = SAMPLE_ANGLE[13:2];
    pre_off = interface_output_config_reg[ZERO_AFTER_BIT] ? raw12 :
              raw12 - angle_processing_config_reg[11:0];
    lin_in = pre_off;
    seg_corr = interface_output_config_reg[LIN_SCALE_BIT] ?
               {lin_seg_reg[lin_in[11:7]][10:0], 1'b0} :
               lin_seg_reg[lin_in[11:7]];
    lin_angle = interface_output_config_reg[LIN_EN_BIT] ?
                lin_in - seg_corr : lin_in;
    if (interface_output_config_reg[ZERO_AFTER_BIT]) begin
      lin_angle = lin_angle - angle_processing_config_reg[11:0];
    end
    dir_angle = angle_processing_config_reg[DIR_BIT] ?
                12'h000 - lin_angle : lin_angle;
    post_angle = angle_processing_config_reg[DIE_ROT_BIT] ?
                 dir_angle + HALF_TURN : dir_angle;
  end

  // threshold in 14-bit LSBs; users see this sample's filter value
  logic [13:0] diff14, hys_next;
  always_comb begin
    diff14   = {post_angle, SAMPLE_ANGLE[1:0]} - hys_angle_reg;
    hys_next = hys_angle_reg;
    if ((diff14[13] ? 14'h0000 - diff14 : diff14) >
        {8'h00, angle_processing_config_reg[17:12]}) begin
      hys_next = {post_angle, SAMPLE_ANGLE[1:0]};
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      hys_angle_reg <= 14'h0000;
    end else if (SAMPLE_VALID) begin
      hys_angle_reg <= hys_next;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      TURNS_ANGLE_REGISTER <= 12'h000;
    end else if (SAMPLE_VALID) begin
      TURNS_ANGLE_REGISTER <= interface_output_config_reg[TURNS_HYS_BIT] ?
                              hys_next[13:2] : post_angle;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      PWM_ANGLE <= 12'h000;
    end else if (SAMPLE_VALID) begin
      PWM_ANGLE <= interface_output_config_reg[PWM_HYS_BIT] ?
                   hys_next[13:2] : post_angle;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output averaging; plain mean, wraparound near zero not unwrapped
  logic [3:0] orate;
  assign orate = (angle_processing_config_reg[23:20] > ORATE_MAX) ?
                 ORATE_MAX : angle_processing_config_reg[23:20];

  always_ff @(posedge CLK) begin
    if (RESET) begin
      acc_reg      <= 26'h0;
      cnt_reg      <= 13'h0;
      OUTPUT_ANGLE <= 12'h000;
      OUTPUT_VALID <= 1'b0;
    end else begin
      OUTPUT_VALID <= 1'b0;
      if (SAMPLE_VALID) begin
        if (cnt_reg == 13'((14'h1 << orate) - 14'h1)) begin
          OUTPUT_ANGLE <= 12'((acc_reg + {14'h0, post_angle}) >> orate);
          OUTPUT_VALID <= 1'b1;
          acc_reg      <= 26'h0;
          cnt_reg      <= 13'h0;
        end else begin
          acc_reg <= acc_reg + {14'h0, post_angle};
          cnt_reg <= cnt_reg + 13'h1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // PWM pin control; tristate latch cleared only by reset or peo low
  logic err_any;
  assign err_any = AGGREGATE_ERROR_FLAG;

  always_ff @(posedge CLK) begin
    if (RESET) begin
      pwm_latch_reg <= 1'b0;
    end else begin
      if (!interface_output_config_reg[ERR_OUT_BIT]) begin
        pwm_latch_reg <= 1'b0;
      end else if (err_any && !interface_output_config_reg[ERR_SEL_BIT]) begin
        pwm_latch_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      PWM_MODE       <= EOMAC_PWM_OFF;
      PWM_OE         <= 1'b0;
      PWM_ERROR_CODE <= ERR_SOURCES;
    end else begin
      PWM_ERROR_CODE <= first_err(ERROR_SOURCES & ~error_mask_config_reg);
      if (!interface_output_config_reg[PWM_EN_BIT]) begin
        PWM_MODE <= EOMAC_PWM_OFF;
        PWM_OE   <= 1'b0;
      end else if (pwm_latch_reg) begin
        PWM_MODE <= EOMAC_PWM_TRI;
        PWM_OE   <= 1'b0;
      end else if (interface_output_config_reg[ERR_OUT_BIT] && err_any &&
                   interface_output_config_reg[ERR_SEL_BIT]) begin
        PWM_MODE <= EOMAC_PWM_ERR;
        PWM_OE   <= 1'b1;
      end else begin
        PWM_MODE <= EOMAC_PWM_ANGLE;
        PWM_OE   <= 1'b1;
      end
    end
  end

  // Control word for the serial and PWM generators
  always_ff @(posedge CLK) begin
    if (RESET) begin
      CTRL <= '0;
    end else begin
      CTRL.crc_check_enable <= interface_output_config_reg[CRC_CHK_BIT];
      CTRL.extra_clock_tolerance <=
        interface_output_config_reg[XCLK_TOL_BIT];
      CTRL.supply_protocol_disable <=
        interface_output_config_reg[SUPPLY_DIS_BIT];
      CTRL.linearization_scale <= interface_output_config_reg[LIN_SCALE_BIT];
      CTRL.pwm_freq_sel <= interface_output_config_reg[19:16];
      CTRL.pwm_band_sel <= interface_output_config_reg[22:20];
      CTRL.pwm_half_freq <= interface_output_config_reg[ERR_OUT_BIT] &&
                            interface_output_config_reg[ERR_SEL_BIT] &&
                            err_any;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  sequence err_set_s;
    interface_output_config_reg[ERR_OUT_BIT] &&
    !interface_output_config_reg[ERR_SEL_BIT] && err_any;
  endsequence

  mask_flag_a: assert property (@(posedge CLK) disable iff (RESET)
    ##1 AGGREGATE_ERROR_FLAG ==
        |($past(ERROR_SOURCES) & ~$past(error_mask_config_reg)))
    else $error("aggregate flag mismatch");
  warn_mask_a: assert property (@(posedge CLK) disable iff (RESET)
    error_mask_config_reg[WARN_MASK_BIT] |=> !WARNING_SUMMARY_BIT)
    else $error("warning summary not masked");
  tri_hold_a: assert property (@(posedge CLK) disable iff (RESET)
    err_set_s ##1 interface_output_config_reg[ERR_OUT_BIT] [*2]
      |-> pwm_latch_reg)
    else $error("pwm tristate latch not held");
  pwm_off_a: assert property (@(posedge CLK) disable iff (RESET)
    !interface_output_config_reg[PWM_EN_BIT] |=> !PWM_OE)
    else $error("pwm driven while disabled");
  err_mode_a: assert property (@(posedge CLK) disable iff (RESET)
    PWM_MODE == EOMAC_PWM_ERR |-> $past(err_any) && PWM_OE)
    else $error("error mode without error");
  crc_cfg_a: assert property (@(posedge CLK) disable iff (RESET)
    ##1 CTRL.crc_check_enable ==
        $past(interface_output_config_reg[CRC_CHK_BIT]))
    else $error("crc enable not forwarded");
  die_rot_a: assert property (@(posedge CLK) disable iff (RESET)
    post_angle == (angle_processing_config_reg[DIE_ROT_BIT] ?
                   dir_angle + HALF_TURN : dir_angle))
    else $error("die rotate wrong");
  avg_cnt_a: assert property (@(posedge CLK) disable iff (RESET)
    OUTPUT_VALID |-> $past(cnt_reg) == 13'((14'h1 << orate) - 14'h1))
    else $error("averaging count wrong");

endmodule : eomac_config

// file: sim/eomac_sample_src.sv
// Raw angle source standing in for the front-end sample path
`timescale 1ns/10ps

module eomac_sample_src (
  input  wire logic        clk,   // Bench clock
  output logic             valid, // One-cycle sample strobe
  output logic [13:0]      angle  // Raw 14-bit angle
);
  // Quiet start, nothing offered
  initial begin
    valid = 1'b0;
    angle = 14'h0000;
  end

  // One sample, then a gap cycle; the idle bus shows inverted data so a
  // design that samples outside the strobe picks up garbage
  task automatic send(input logic [13:0] a);
    valid <= 1'b1;
    angle <= a;
    @(posedge clk);
    valid <= 1'b0;
    angle <= ~a;
    @(posedge clk);
  endtask
endmodule // eomac_sample_src

// file: sim/error_mask_output_angle_config_tb.sv
// Self-checking bench for the mask, output and angle config bank
`timescale 1ns/10ps

module error_mask_output_angle_config_tb;
  import eomac_pkg::*;

  logic              clk, rst, rd, wr, warn, svalid, waitreq;
  logic              aflag, wbit, ovalid, oe;
  logic [9:0]        addr;
  logic [31:0]       wdata, rdata, q;
  logic [3:0]        be;
  logic [13:0]       sangle;
  logic [23:0]       errs;
  logic [11:0]       oangle, tangle, pangle, last_out, a0, a1, a2;
  logic [4:0]        ecode;
  eomac_pwm_t        pmode;
  eomac_ctrl_t       ctrl;
  int                bad_count, tests_run, cyc, vcount, v0;
  logic [23:0]       acfg [3] = '{24'h000123, 24'h080123, 24'h040000};
  logic [13:0]       araw [3] = '{14'h2000, 14'h2000, 14'h0400};
  logic [11:0]       aexp [3] = '{12'h6dd, 12'hedd, 12'hf00};

  // 20 MHz clock
  initial clk = 1'b0;
  always #25 clk = ~clk;

  eomac_config dut (
    .CLK(clk), .RESET(rst), .AVS_ADDRESS(addr), .AVS_READ(rd),
    .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be),
    .AVS_READDATA(rdata), .AVS_WAITREQUEST(waitreq),
    .SAMPLE_VALID(svalid), .SAMPLE_ANGLE(sangle), .ERROR_SOURCES(errs),
    .WARNING_ACTIVE(warn), .AGGREGATE_ERROR_FLAG(aflag),
    .WARNING_SUMMARY_BIT(wbit), .OUTPUT_ANGLE(oangle),
    .OUTPUT_VALID(ovalid), .TURNS_ANGLE_REGISTER(tangle),
    .PWM_ANGLE(pangle), .PWM_ERROR_CODE(ecode), .PWM_MODE(pmode),
    .PWM_OE(oe), .CTRL(ctrl));

  eomac_sample_src src (.clk(clk), .valid(svalid), .angle(sangle));

  ////////////////////////////////////////////////////////////////////////
  // Count averaged outputs and keep the last one
  always @(posedge clk) begin
    if (ovalid === 1'b1) begin
      vcount <= vcount + 1;
      last_out <= oangle;
    end
  end

  // Hang guard; the full run needs roughly 9k cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      bad_count++;
      give_verdict;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Compare seen against expected
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One Avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] b);
    int n;
    n = 0;
    addr <= {2'b00, a};
    wdata <= d;
    be <= b;
    rd <= ~w;
    wr <= w;
    do begin
      @(posedge clk);
      n++;
    end while (waitreq !== 1'b0 && n < 40);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 40) chk(32'h1, 32'h0);
    @(posedge clk);
  endtask

  // Read a word and compare
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0, 4'hf);
    chk(q, exp);
  endtask

  // Flag outputs trail their inputs by one cycle
  task automatic settle;
    repeat (3) @(posedge clk);
  endtask

  // Wait, bounded, for a new averaged output
  task automatic wait_out;
    int n;
    n = 0;
    while (vcount == v0 && n < 20) begin
      @(posedge clk);
      n++;
    end
  endtask

  // One sample with orate zero gives one output
  task automatic sample(input logic [13:0] r);
    v0 = vcount;
    src.send(r);
    wait_out;
  endtask

  // Summary line, verdict and end of run
  task automatic give_verdict;
    $display("Counts: tests_run=%0d bad_count=%0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rst = 1'b1;
    rd = 1'b0;
    wr = 1'b0;
    addr = 10'h000;
    wdata = 32'h0;
    be = 4'h0;
    errs = 24'h0;
    warn = 1'b0;
    bad_count = 0;
    tests_run = 0;
    cyc = 0;
    vcount = 0;
    v0 = 0;
    last_out = 12'h000;
    repeat (12) @(posedge clk);
    chk(waitreq, 1'b1);
    chk(ecode, ERR_SOURCES);
    chk(pmode, EOMAC_PWM_OFF);
    rst <= 1'b0;
    @(posedge clk);
    // Reset values, lane 3 ignored, partial lanes, unmapped word
    for (int i = 0; i < 3; i++) begin
      rchk(ERROR_MASK_CONFIG_IDX + 8'(i), {8'h00, CFG_RESET});
      bus(1'b1, ERROR_MASK_CONFIG_IDX + 8'(i), 32'hffffffff, 4'hf);
      rchk(ERROR_MASK_CONFIG_IDX + 8'(i), 32'h00ffffff);
      bus(1'b1, ERROR_MASK_CONFIG_IDX + 8'(i), 32'h0, 4'h1);
      rchk(ERROR_MASK_CONFIG_IDX + 8'(i), 32'h00ffff00);
      bus(1'b1, ERROR_MASK_CONFIG_IDX + 8'(i), 32'h0, 4'hf);
    end
    bus(1'b1, 8'hff, 32'h5a5a5a, 4'hf);
    rchk(8'hff, 32'h0);
    // Every mask bit against its own source, then all others masked
    for (int i = 0; i < 24; i++) begin
      errs <= 24'h1 << i;
      bus(1'b1, ERROR_MASK_CONFIG_IDX, 32'h1 << i, 4'hf);
      settle;
      chk(aflag, 1'b0);
      bus(1'b1, ERROR_MASK_CONFIG_IDX, ~(32'h1 << i), 4'hf);
      settle;
      chk(aflag, 1'b1);
    end
    errs <= 24'h0;
    warn <= 1'b1;
    bus(1'b1, ERROR_MASK_CONFIG_IDX, 32'h0, 4'hf);
    settle;
    chk(wbit, 1'b1);
    chk(aflag, 1'b0);
    bus(1'b1, ERROR_MASK_CONFIG_IDX, 32'h800, 4'hf);
    settle;
    chk(wbit, 1'b0);
    warn <= 1'b0;
    // Decoded serial and carrier controls
    bus(1'b1, INTERFACE_OUTPUT_CONFIG_IDX, 32'h005a040b, 4'hf);
    settle;
    chk(ctrl.crc_check_enable, 1'b1);
    chk(ctrl.extra_clock_tolerance, 1'b1);
    chk(ctrl.supply_protocol_disable, 1'b1);
    chk(ctrl.linearization_scale, 1'b1);
    chk(ctrl.pwm_freq_sel, 4'ha);
    chk(ctrl.pwm_band_sel, 3'h5);
    bus(1'b1, INTERFACE_OUTPUT_CONFIG_IDX, 32'h0, 4'hf);
    settle;
    chk(ctrl, 12'h000);
    // PWM pin modes: enable, latched tristate, error duty
    bus(1'b1, INTERFACE_OUTPUT_CONFIG_IDX, 32'h800000, 4'hf);
    settle;
    chk(oe, 1'b1);
    chk(pmode, EOMAC_PWM_ANGLE);
    errs <= 24'h000001;
    bus(1'b1, INTERFACE_OUTPUT_CONFIG_IDX, 32'h802000, 4'hf);
    settle;
    chk(pmode, EOMAC_PWM_TRI);
    chk(oe, 1'b0);
    rchk(ERROR_STATUS_IDX, 32'h5);
    errs <= 24'h0;
    settle;
    chk(pmode, EOMAC_PWM_TRI);
    bus(1'b1, INTERFACE_OUTPUT_CONFIG_IDX, 32'h800000, 4'hf);
    settle;
    chk(pmode, EOMAC_PWM_ANGLE);
    errs <= 24'h000028;
    bus(1'b1, INTERFACE_OUTPUT_CONFIG_IDX, 32'h803000, 4'hf);
    settle;
    chk(pmode, EOMAC_PWM_ERR);
    chk(ecode, 5'h03);
    chk(ctrl.pwm_half_freq, 1'b1);
    chk(oe, 1'b1);
    bus(1'b1, INTERFACE_OUTPUT_CONFIG_IDX, 32'h003000, 4'hf);
    settle;
    chk(oe, 1'b0);
    chk(pmode, EOMAC_PWM_OFF);
    errs <= 24'h0;
    bus(1'b1, INTERFACE_OUTPUT_CONFIG_IDX, 32'h0, 4'hf);
    // Offset, die rotation and direction on single samples
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, ANGLE_PROCESSING_CONFIG_IDX, {8'h00, acfg[i]}, 4'hf);
      sample(araw[i]);
      chk(last_out, aexp[i]);
    end
    // Hysteresis of 8 fine LSBs on turns and PWM angles
    bus(1'b1, ANGLE_PROCESSING_CONFIG_IDX, 32'h008000, 4'hf);
    bus(1'b1, INTERFACE_OUTPUT_CONFIG_IDX, 32'h004004, 4'hf);
    sample(14'h1000);
    sample(14'h1000);
    sample(14'h1004);
    chk(last_out, 12'h401);
    chk(tangle, 12'h400);
    chk(pangle, 12'h400);
    rchk(ANGLE_STATUS_IDX, 32'h00400401);
    bus(1'b1, INTERFACE_OUTPUT_CONFIG_IDX, 32'h0, 4'hf);
    sample(14'h1004);
    chk(tangle, 12'h401);
    chk(pangle, 12'h401);
    bus(1'b1, INTERFACE_OUTPUT_CONFIG_IDX, 32'h004004, 4'hf);
    sample(14'h1010);
    chk(tangle, 12'h404);
    // Flat correction table, off, scale 0 and scale 1
    bus(1'b1, ANGLE_PROCESSING_CONFIG_IDX, 32'h0, 4'hf);
    for (int s = 0; s < LIN_SEGS; s++) begin
      bus(1'b1, LIN_SEG_IDX + 8'(s), 32'h100, 4'hf);
    end
    rchk(LIN_SEG_IDX + 8'd31, 32'h100);
    bus(1'b1, INTERFACE_OUTPUT_CONFIG_IDX, 32'h0, 4'hf);
    sample(14'h2000);
    a0 = last_out;
    bus(1'b1, INTERFACE_OUTPUT_CONFIG_IDX, 32'h000800, 4'hf);
    sample(14'h2000);
    a1 = last_out;
    bus(1'b1, INTERFACE_OUTPUT_CONFIG_IDX, 32'h000c00, 4'hf);
    sample(14'h2000);
    a2 = last_out;
    chk(a0, 12'h800);
    chk(a0 !== a1, 1'b1);
    chk(12'(a0 - a2), 12'((a0 - a1) << 1));
    // Averaging of 4, then field 13 clamped to 4096 samples
    bus(1'b1, INTERFACE_OUTPUT_CONFIG_IDX, 32'h0, 4'hf);
    bus(1'b1, ANGLE_PROCESSING_CONFIG_IDX, 32'h200000, 4'hf);
    v0 = vcount;
    for (int k = 1; k <= 4; k++) begin
      src.send(14'(k << 10));
    end
    wait_out;
    chk(vcount - v0, 1);
    chk(last_out, 12'h280);
    bus(1'b1, ANGLE_PROCESSING_CONFIG_IDX, 32'hd00000, 4'hf);
    v0 = vcount;
    repeat (4095) src.send(14'h2000);
    settle;
    chk(vcount - v0, 0);
    src.send(14'h2000);
    wait_out;
    chk(vcount - v0, 1);
    chk(last_out, 12'h800);
    give_verdict;
  end
endmodule // error_mask_output_angle_config_tb
